// ### logic/bus_intercon_pkg.sv
package bus_intercon_pkg;
   // Default port count and bus widths
   localparam int NUM_PORTS = 4;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int SEL_W = 4;
   // Slave region field: top address bits 15..14
   localparam int REGION_MSB = 15;
   localparam int REGION_LSB = 14;

   // Master request bundle as seen by the shared bus
   typedef struct packed {
      logic [ADDR_W-1:0] adr;
      logic [DATA_W-1:0] dat;
      logic [SEL_W-1:0] sel;
      logic we;
      logic stb;
   } mreq_t;

   // Slave termination bundle
   typedef struct packed {
      logic ack;
      logic rty;
      logic err;
   } term_t;

   typedef enum logic {ARB_IDLE, ARB_OWNED} arb_state_t;
endpackage

// ### logic/shared_bus_intercon.sv
`timescale 1ns/100ps
module shared_bus_intercon #(
   parameter int N = bus_intercon_pkg::NUM_PORTS,
   parameter int AW = bus_intercon_pkg::ADDR_W,
   parameter int DW = bus_intercon_pkg::DATA_W,
   parameter int SW = bus_intercon_pkg::SEL_W,
   parameter int RMSB = bus_intercon_pkg::REGION_MSB,
   parameter int RLSB = bus_intercon_pkg::REGION_LSB,
   parameter int GW = (N > 1) ? $clog2(N) : 1
) (
   // System clock and synchronized reset
   input wire logic ref_clk,
   input wire logic reset,
   // Master side outputs, one entry per master
   input wire logic [N-1:0] m_cyc,
   input wire logic [N-1:0] m_stb,
   input wire logic [N-1:0] m_we,
   input wire logic [N*AW-1:0] m_adr,
   input wire logic [N*DW-1:0] m_dat_w,
   input wire logic [N*SW-1:0] m_sel,
   // Master side inputs
   output logic [N-1:0] m_ack,
   output logic [N-1:0] m_rty,
   output logic [N-1:0] m_err,
   output logic [DW-1:0] m_dat_r,
   // Shared slave bus
   output logic [AW-1:0] s_adr,
   output logic [DW-1:0] s_dat_w,
   output logic [SW-1:0] s_sel,
   output logic s_we,
   output logic s_cyc,
   output logic [N-1:0] s_stb,
   // Slave returns
   input wire logic [N-1:0] s_ack,
   input wire logic [N-1:0] s_rty,
   input wire logic [N-1:0] s_err,
   input wire logic [N*DW-1:0] s_dat_r,
   // Arbiter status
   output logic [N-1:0] gnt,
   output logic [GW-1:0] gnt_enc
);

   // Arbiter state kept as one packed record
   typedef struct packed {
      bus_intercon_pkg::arb_state_t state;
      logic [GW-1:0] owner;
      logic [GW-1:0] last;
   } arb_t;

   arb_t cur;
   arb_t next_cur;

   // Round-robin pick: first requester after the previous owner
   function automatic logic [GW:0] rr_pick(input logic [N-1:0] req,
                                           input logic [GW-1:0] prev);
      logic [GW:0] res;
      int idx;
      res = '0;
      for (int k = N; k >= 1; k--) begin
         idx = (int'(prev) + k) % N;
         if (req[idx]) begin
            res = {1'b1, GW'(idx)};
         end
      end
      return res;
   endfunction

   // Region decode, used for strobes and the read-back mux
   function automatic logic [GW-1:0] region_of(input logic [AW-1:0] a);
      return GW'(a[RMSB:RLSB]);
   endfunction

   logic [GW:0] pick;
   logic owner_cyc;

   // Arbiter next state: hold while owner cycles, else re-arbitrate
   always_comb begin
      next_cur = cur;
      pick = rr_pick(m_cyc, cur.last);
      owner_cyc = m_cyc[cur.owner];
      case (cur.state)
         bus_intercon_pkg::ARB_IDLE: begin
            if (pick[GW]) begin
               next_cur.state = bus_intercon_pkg::ARB_OWNED;
               next_cur.owner = pick[GW-1:0];
            end
         end
         bus_intercon_pkg::ARB_OWNED: begin
            // Release costs one idle cycle so the old owner never retains
            // a grant it no longer asks for
            if (!owner_cyc) begin
               next_cur.state = bus_intercon_pkg::ARB_IDLE;
               next_cur.last = cur.owner;
            end
         end
         default: begin
            next_cur.state = bus_intercon_pkg::ARB_IDLE;
         end
      endcase
      if (reset) begin
         next_cur.state = bus_intercon_pkg::ARB_IDLE;
         next_cur.owner = '0;
         next_cur.last = GW'(N - 1);
      end
   end

   // State register, synchronous reset folded into next value
   always_ff @(posedge ref_clk) begin
      cur <= next_cur;
   end

   logic granted;
   assign granted = (cur.state == bus_intercon_pkg::ARB_OWNED);

   // Grant lines, one-hot and encoded
   always_comb begin
      gnt = '0;
      if (granted) begin
         gnt[cur.owner] = 1'b1;
      end
      gnt_enc = cur.owner;
   end

   // Shared bus multiplexors, no three-state drive
   always_comb begin
      s_adr = m_adr[cur.owner*AW +: AW];
      s_dat_w = m_dat_w[cur.owner*DW +: DW];
      s_sel = m_sel[cur.owner*SW +: SW];
      s_we = granted & m_we[cur.owner];
      s_cyc = granted & m_cyc[cur.owner];
   end

   logic shared_stb;
   assign shared_stb = granted & m_stb[cur.owner] & m_cyc[cur.owner];

   // Address comparator drives one slave strobe
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_stb
         assign s_stb[g] = shared_stb &&
            (region_of(s_adr) == GW'(g));
      end
   endgenerate

   // Terminations ORed, then gated by grant
   logic any_ack;
   logic any_rty;
   logic any_err;
   always_comb begin
      any_ack = |s_ack;
      any_rty = |s_rty;
      any_err = |s_err;
      m_ack = gnt & {N{any_ack}};
      m_rty = gnt & {N{any_rty}};
      m_err = gnt & {N{any_err}};
   end

   // Read data from the addressed slave
   assign m_dat_r = s_dat_r[region_of(s_adr)*DW +: DW];

   // Assertions
   property p_onehot;
      @(posedge ref_clk) disable iff (reset) $onehot0(gnt);
   endproperty
   a_onehot: assert property (p_onehot) else $error("grant not one-hot");

   property p_grant_req;
      @(posedge ref_clk) disable iff (reset)
         (!granted && |m_cyc) |=> granted;
   endproperty
   a_grant_req: assert property (p_grant_req) else $error("no grant");

   property p_reset_nogrant;
      @(posedge ref_clk) reset |=> gnt == '0;
   endproperty
   a_reset_nogrant: assert property (p_reset_nogrant)
      else $error("grant in reset");

   property p_hold;
      @(posedge ref_clk) disable iff (reset)
         (granted && m_cyc[cur.owner]) |=> $stable(gnt);
   endproperty
   a_hold: assert property (p_hold) else $error("grant moved");

   property p_release;
      @(posedge ref_clk) disable iff (reset)
         (granted && !m_cyc[cur.owner]) |=> gnt == '0;
   endproperty
   a_release: assert property (p_release) else $error("no release");

   property p_term_gated;
      @(posedge ref_clk) disable iff (reset)
         ((m_ack | m_rty | m_err) & ~gnt) == '0;
   endproperty
   a_term_gated: assert property (p_term_gated)
      else $error("term to ungranted");

   property p_ack_route;
      @(posedge ref_clk) disable iff (reset)
         (granted && |s_ack) |-> m_ack[cur.owner];
   endproperty
   a_ack_route: assert property (p_ack_route) else $error("ack lost");

   property p_stb_decode;
      @(posedge ref_clk) disable iff (reset)
         s_stb != '0 |-> $onehot(s_stb) && s_stb[s_adr[RMSB:RLSB]] &&
            m_stb[gnt_enc] && granted;
   endproperty
   a_stb_decode: assert property (p_stb_decode)
      else $error("wrong slave strobe");

   property p_adr_mux;
      @(posedge ref_clk) disable iff (reset)
         granted |-> s_adr == m_adr[gnt_enc*AW +: AW];
   endproperty
   a_adr_mux: assert property (p_adr_mux) else $error("adr mux");

   property p_rr_next;
      @(posedge ref_clk) disable iff (reset)
         (!granted && m_cyc[(cur.last + 1) % N]) |=>
            gnt_enc == GW'((int'($past(cur.last)) + 1) % N);
   endproperty
   a_rr_next: assert property (p_rr_next) else $error("rr order");

endmodule // shared_bus_intercon

// ### test/slave_bank.sv
`timescale 1ns/100ps
// Four slaves behind the shared bus, one region each
module slave_bank #(
   parameter int N = 4,
   parameter int AW = 16,
   parameter int DW = 32
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Shared bus from the interconnect
   input wire logic [N-1:0] s_stb,
   input wire logic [AW-1:0] s_adr,
   // Answer kind and wait states, set by the bench
   input wire logic [1:0] kind,
   input wire logic [7:0] slow,
   // Slave returns
   output logic [N-1:0] s_ack,
   output logic [N-1:0] s_rty,
   output logic [N-1:0] s_err,
   output logic [N*DW-1:0] s_dat_r
);
   logic [7:0] cnt;
   logic [7:0] noise;
   // Wait counter; noise keeps idle read lines from looking valid
   always_ff @(posedge ref_clk) begin
      noise <= reset ? 8'h00 : noise + 8'h3B;
      cnt <= (reset || s_stb == '0) ? 8'h00 : cnt + 8'h01;
   end
   // Answer only while strobed, once the wait has run out
   for (genvar i = 0; i < N; i++) begin : g_slv
      wire hit = s_stb[i] && cnt == slow;
      assign s_ack[i] = hit && kind == 2'h0;
      assign s_rty[i] = hit && kind == 2'h1;
      assign s_err[i] = hit && kind == 2'h2;
      assign s_dat_r[i*DW +: DW] = s_stb[i] ? {8'(i), 8'hD0, s_adr}
         : {4{noise}};
   end
endmodule // slave_bank

// ### test/shared_bus_mux_intercon_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module shared_bus_mux_intercon_test;
   localparam int N = bus_intercon_pkg::NUM_PORTS;
   localparam int AW = bus_intercon_pkg::ADDR_W;
   localparam int DW = bus_intercon_pkg::DATA_W;
   localparam int SW = bus_intercon_pkg::SEL_W;
   typedef struct packed {
      logic [1:0] m;
      logic [15:0] a;
      logic w;
      logic [1:0] k;
      logic [7:0] s;
   } row_t;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [N-1:0] m_cyc = '0, m_stb = '0, m_we = '0;
   logic [N*AW-1:0] m_adr = '0;
   logic [N*DW-1:0] m_dat_w = '0;
   logic [N*SW-1:0] m_sel = '0;
   logic [1:0] kind = 2'h0;
   logic [7:0] slow = 8'h00;
   logic [N-1:0] m_ack, m_rty, m_err, s_stb, s_ack, s_rty, s_err, gnt;
   logic [DW-1:0] m_dat_r, s_dat_w;
   logic [AW-1:0] s_adr;
   logic [SW-1:0] s_sel;
   logic s_we, s_cyc;
   logic [N*DW-1:0] s_dat_r;
   logic [1:0] gnt_enc;
   int fail_count = 0;
   int n_checks = 0;
   // Ordinary cycles: master, address, write, answer kind, wait states
   row_t rows [5] = '{'{2'h2, 16'h0004, 1'h1, 2'h0, 8'h00},
      '{2'h1, 16'h7FFC, 1'h0, 2'h0, 8'h02},
      '{2'h3, 16'hC010, 1'h0, 2'h1, 8'h01},
      '{2'h0, 16'h8000, 1'h1, 2'h2, 8'h00},
      '{2'h2, 16'hBFFF, 1'h0, 2'h0, 8'h05}};

   shared_bus_intercon i_shared_bus_intercon (.ref_clk, .reset, .m_cyc,
      .m_stb, .m_we, .m_adr, .m_dat_w, .m_sel, .m_ack, .m_rty, .m_err,
      .m_dat_r, .s_adr, .s_dat_w, .s_sel, .s_we, .s_cyc, .s_stb, .s_ack,
      .s_rty, .s_err, .s_dat_r, .gnt, .gnt_enc);
   slave_bank i_slave_bank (.ref_clk, .reset, .s_stb, .s_adr, .kind, .slow,
      .s_ack, .s_rty, .s_err, .s_dat_r);

   // 10 MHz clock
   initial forever #50 ref_clk = ~ref_clk;

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Raise cycle and strobe; caller sits just after a falling edge
   task automatic req(int m, logic [15:0] a, logic w);
      m_cyc[m] = 1'b1;
      m_stb[m] = 1'b1;
      m_we[m] = w;
      m_adr[m*AW +: AW] = a;
      m_dat_w[m*DW +: DW] = {16'h5A5A, a};
      m_sel[m*SW +: SW] = a[3:0];
   endtask

   // Wait for grant, check bus and answer, then release; loops are bounded
   task automatic serve(int m);
      logic [15:0] a;
      int i;
      a = m_adr[m*AW +: AW];
      for (i = 0; i < 20 && gnt[m] !== 1'b1; i++) @(negedge ref_clk);
      if (i == 20) begin fail_count++; test_done(); end
      `CHK(gnt, 4'h1 << m)
      `CHK(gnt_enc, 2'(m))
      `CHK({s_cyc, s_adr, s_we, s_dat_w, s_sel}, {1'b1, a, m_we[m],
         m_dat_w[m*DW +: DW], m_sel[m*SW +: SW]})
      `CHK(s_stb, 4'h1 << a[15:14])
      for (i = 0; i < 20 && (m_ack[m] | m_rty[m] | m_err[m]) !== 1'b1;
         i++) begin
         `CHK(m_ack | m_rty | m_err, 4'h0)
         @(negedge ref_clk);
      end
      if (i == 20) begin fail_count++; test_done(); end
      `CHK({m_ack[m], m_rty[m], m_err[m]}, 3'b100 >> kind)
      `CHK((m_ack | m_rty | m_err) & ~gnt, 4'h0)
      `CHK(gnt[m], 1'b1)
      if (!m_we[m]) `CHK(m_dat_r, {8'(a[15:14]), 8'hD0, a})
      m_cyc[m] = 1'b0;
      m_stb[m] = 1'b0;
      @(posedge ref_clk);
      #1 `CHK({gnt, s_stb, s_cyc}, 9'h000)
   endtask

   // Reset with all four requesting, then contention, table, skipping
   initial begin
      repeat (8) @(negedge ref_clk);
      for (int m = 0; m < N; m++) req(m, {2'(3 - m), 14'(m * 4)}, m[0]);
      repeat (8) @(negedge ref_clk);
      `CHK({gnt, s_stb, m_ack | m_rty | m_err}, 12'h000)
      reset = 1'b0;
      $display("test reset done");
      for (int m = 0; m < N; m++) serve(m);
      $display("test contention done");
      foreach (rows[r]) begin
         @(negedge ref_clk);
         kind = rows[r].k;
         slow = rows[r].s;
         req(rows[r].m, rows[r].a, rows[r].w);
         serve(rows[r].m);
      end
      $display("test table done");
      // Last owner was 2; master 3 idle, so 0 must win over 1
      @(negedge ref_clk);
      kind = 2'h0;
      slow = 8'h01;
      req(1, 16'h4444, 1'b0);
      req(0, 16'hC000, 1'b1);
      serve(0);
      serve(1);
      $display("test skip done");
      // Reset while master 3 owns the bus, before its slave answers
      @(negedge ref_clk);
      req(3, 16'h0000, 1'b0);
      @(negedge ref_clk);
      `CHK(gnt, 4'h8)
      reset = 1'b1;
      @(negedge ref_clk);
      `CHK({gnt, s_stb, s_cyc}, 9'h000)
      reset = 1'b0;
      // Request held through reset is granted again afterwards
      serve(3);
      $display("test mid reset done");
      test_done();
   end
endmodule // shared_bus_mux_intercon_test
